// file: pkg/hwwdt_pkg.sv
/*
 Shared constants for the hardware watchdog: register addresses, key values,
 counter widths and the reset-pulse length.
 Assumes a single 200 MHz clock domain standing in for the machine-cycle clock.
*/
`default_nettype none
package hwwdt_pkg;
  localparam logic [7:0] hwwdt_restart_addr = 8'hA6;
  localparam logic [7:0] hwwdt_period_addr = 8'hA7;
  localparam logic [7:0] hwwdt_key_first = 8'h1E;
  localparam logic [7:0] hwwdt_key_second = 8'hE1;
  localparam int hwwdt_base_bits = 14;
  localparam int hwwdt_ext_bits = 7;
  localparam int hwwdt_sel_bits = 3;
  localparam logic [hwwdt_base_bits-1:0] hwwdt_base_terminal = 14'h3FFF;
  localparam logic [hwwdt_sel_bits-1:0] hwwdt_sel_reset = 3'h0;
  localparam logic [hwwdt_ext_bits-1:0] hwwdt_ext_zero = 7'h00;
  // reset pulse length in oscillator periods, one oscillator period per clock here
  localparam int hwwdt_pulse_periods = 96;
  localparam logic [6:0] hwwdt_pulse_last = 7'(hwwdt_pulse_periods - 1);
  typedef enum logic [1:0] {
    hwwdt_off = 2'h0,
    hwwdt_run = 2'h1,
    hwwdt_fire = 2'h3
  } hwwdt_state_t;
endpackage : hwwdt_pkg
`default_nettype wire

// file: pkg/hwwdt_key_if.sv
/*
 Carrier between the watchdog core and its key-sequence checker.
 Assumes both ends sit on the same clock.
*/
`default_nettype none
interface hwwdt_key_if;
  logic wr_en;
  logic [7:0] wr_data;
  logic key_ok;
  modport checker_end (input wr_en, input wr_data, output key_ok);
  modport core_end (output wr_en, output wr_data, input key_ok);
endinterface : hwwdt_key_if
`default_nettype wire

// file: logic/hwwdt_key_check.sv
/*
 Key-sequence checker: pulses key_ok for one cycle when a second-key write
 directly follows a first-key write to the restart register.
 Assumes writes arrive as one-cycle strobes, synchronous to clk.
*/
`default_nettype none
module hwwdt_key_check (
  input wire logic clk,
  input wire logic rst_n,
  hwwdt_key_if.checker_end kif
);
  logic armed_ff;
  logic key_ok_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_ff <= 1'b0;
    end else if (kif.wr_en) begin
      armed_ff <= (kif.wr_data == hwwdt_pkg::hwwdt_key_first);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_ok_ff <= 1'b0;
    end else begin
      key_ok_ff <= kif.wr_en && armed_ff && (kif.wr_data == hwwdt_pkg::hwwdt_key_second);
    end
  end

  assign kif.key_ok = key_ok_ff;
endmodule // hwwdt_key_check
`default_nettype wire

// file: logic/hwwdt_top.sv
/*
 Hardware watchdog: key-enabled 14-bit counter with a 7-bit extension,
 period-select register and a fixed-length reset pulse output.
 Holds the reset synchroniser, register decode, key-pair checker instance,
 timeout compare, state machine, counters and the special-register read mux.
 Assumes a synchronous special-register write/read port and that clk runs
 only while the oscillator runs; int_hold is high while an external interrupt
 pin is held low during power-down exit. The reset pulse is only driven out;
 resetting the rest of the system is left to the surroundings, and
 the block itself simply returns to off after the pulse.
*/
`default_nettype none
// Functional notes
// - off after reset; enabled only by writing 1E then E1 to restart register.
// - active counter advances by one each machine cycle while clock runs.
// - once active, software cannot stop it; only reset or overflow does.
// - software restarts count by writing the key pair; device restarts count.
// - base counter is 14 bits, terminal count 16383.
// - overflow drives high reset pulse of 96 oscillator periods.
// - restart register is write-only; reads show nothing of watchdog state.
// - counter cannot be read or loaded by software.
// - seven-bit prescaler extends timeout, selected by period register.
// - select bits choose 2^14-1 up to 2^21-1 cycles, one power per step.
// - select bits reset to zero; upper bits undefined after reset.
// - after power-down exit by interrupt, counting waits while pin is low.
module hwwdt_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_ff,
  input wire logic int_hold,
  output logic wdt_rst_out_ff,
  output logic wdt_active_ff
);
  logic rst_sync1_ff;
  logic rst_sync2_ff;
  logic srst_n;
  logic restart_wr;
  logic period_wr;
  logic period_rd;

  // one strobe qualified by one special-register address
  function automatic logic reg_hit(
    input logic strobe,
    input logic [7:0] addr,
    input logic [7:0] target
  );
    return strobe && (addr == target);
  endfunction

  assign restart_wr = reg_hit(reg_wr, reg_addr, hwwdt_pkg::hwwdt_restart_addr);
  assign period_wr = reg_hit(reg_wr, reg_addr, hwwdt_pkg::hwwdt_period_addr);
  assign period_rd = reg_hit(reg_rd, reg_addr, hwwdt_pkg::hwwdt_period_addr);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync1_ff <= 1'b0;
      rst_sync2_ff <= 1'b0;
    end else begin
      rst_sync1_ff <= 1'b1;
      rst_sync2_ff <= rst_sync1_ff;
    end
  end
  assign srst_n = rst_sync2_ff;

  hwwdt_key_if kif ();
  assign kif.wr_en = restart_wr;
  assign kif.wr_data = reg_wdata;

  // key pair checker sees restart-register writes only
  hwwdt_key_check u_key (
    .clk(clk),
    .rst_n(srst_n),
    .kif(kif)
  );

  hwwdt_pkg::hwwdt_state_t state_ff;
  hwwdt_pkg::hwwdt_state_t nxt_state;
  logic [hwwdt_pkg::hwwdt_base_bits-1:0] base_ff;
  logic [hwwdt_pkg::hwwdt_ext_bits-1:0] ext_ff;
  logic [hwwdt_pkg::hwwdt_sel_bits-1:0] sel_ff;
  logic [4:0] upper_ff;
  logic [6:0] pulse_ff;
  logic expire;
  logic base_full;
  logic count_clear;
  logic count_step;

  // extension bits that must be all ones for the selected timeout
  function automatic logic [hwwdt_pkg::hwwdt_ext_bits-1:0] ext_mask(
    input logic [hwwdt_pkg::hwwdt_sel_bits-1:0] sel
  );
    logic [hwwdt_pkg::hwwdt_ext_bits:0] ones;
    ones = (8'h01 << sel) - 8'h01;
    return ones[hwwdt_pkg::hwwdt_ext_bits-1:0];
  endfunction

  assign base_full = (base_ff == hwwdt_pkg::hwwdt_base_terminal);
  // expire when total count reaches 2^(14+sel)-1
  assign expire = base_full
    && ((ext_ff & ext_mask(sel_ff)) == ext_mask(sel_ff));

  // a key pair, or any state but run, zeroes the whole count
  assign count_clear = kif.key_ok || (state_ff != hwwdt_pkg::hwwdt_run);
  // counting freezes while the interrupt pin holds the power-down exit
  assign count_step = !int_hold && !expire;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      hwwdt_pkg::hwwdt_off: begin
        if (kif.key_ok) begin
          nxt_state = hwwdt_pkg::hwwdt_run;
        end
      end
      hwwdt_pkg::hwwdt_run: begin
        if (expire && !kif.key_ok && !int_hold) begin
          nxt_state = hwwdt_pkg::hwwdt_fire;
        end
      end
      hwwdt_pkg::hwwdt_fire: begin
        if (pulse_ff == hwwdt_pkg::hwwdt_pulse_last) begin
          nxt_state = hwwdt_pkg::hwwdt_off;
        end
      end
      default: nxt_state = hwwdt_pkg::hwwdt_off;
    endcase
  end

  // state register; any reset lands in off
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      state_ff <= hwwdt_pkg::hwwdt_off;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // base counter: no software load or read path exists
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      base_ff <= '0;
    end else if (count_clear) begin
      base_ff <= '0;
    end else if (count_step) begin
      base_ff <= base_ff + 1'b1;
    end
  end

  // prescaler extension steps when the base counter wraps
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      ext_ff <= hwwdt_pkg::hwwdt_ext_zero;
    end else if (count_clear) begin
      ext_ff <= hwwdt_pkg::hwwdt_ext_zero;
    end else if (count_step && base_full) begin
      ext_ff <= ext_ff + 1'b1;
    end
  end

  // pulse length, one oscillator period per clock
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      pulse_ff <= '0;
    end else if (state_ff == hwwdt_pkg::hwwdt_fire) begin
      pulse_ff <= pulse_ff + 1'b1;
    end else begin
      pulse_ff <= '0;
    end
  end

  // reset pulse taken from the next state so it leaves a flop
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      wdt_rst_out_ff <= 1'b0;
    end else begin
      wdt_rst_out_ff <= (nxt_state == hwwdt_pkg::hwwdt_fire);
    end
  end

  // status: high while counting is enabled
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      wdt_active_ff <= 1'b0;
    end else begin
      wdt_active_ff <= (nxt_state == hwwdt_pkg::hwwdt_run);
    end
  end

  // period-select register: upper bits hold whatever was written
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      sel_ff <= hwwdt_pkg::hwwdt_sel_reset;
    end else if (period_wr) begin
      sel_ff <= reg_wdata[hwwdt_pkg::hwwdt_sel_bits-1:0];
    end
  end

  // upper bits carry no reset value
  always_ff @(posedge clk) begin
    if (period_wr) begin
      upper_ff <= reg_wdata[7:hwwdt_pkg::hwwdt_sel_bits];
    end
  end

  // read mux: restart register and unknown addresses read as zero
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      reg_rdata_ff <= '0;
    end else if (period_rd) begin
      reg_rdata_ff <= {upper_ff, sel_ff};
    end else begin
      reg_rdata_ff <= '0;
    end
  end
endmodule // hwwdt_top
`default_nettype wire

// file: tb/hwwdt_top_asserts.sv
/* Checker for hwwdt_top: key, pulse and read-back relations.
 Assumes binding to hwwdt_top and its ports only. */
`default_nettype none
module hwwdt_top_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_ff,
  input wire logic int_hold,
  input wire logic wdt_rst_out_ff,
  input wire logic wdt_active_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] pulse_ff;
  logic k1, k2;
  assign k1 = reg_wr && reg_addr == 8'hA6 && reg_wdata == 8'h1E;
  assign k2 = reg_wr && reg_addr == 8'hA6 && reg_wdata == 8'hE1;
  // high cycles of the reset pulse so far
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_ff <= 8'h00;
    end else begin
      pulse_ff <= wdt_rst_out_ff ? pulse_ff + 8'h01 : 8'h00;
    end
  end
  pulse_len_a: assert property (
    $fell(wdt_rst_out_ff) |-> pulse_ff == 8'h60) else $error("reset pulse length wrong");
  pulse_cap_a: assert property (
    wdt_rst_out_ff |-> pulse_ff < 8'h60) else $error("reset pulse too long");
  fire_stop_a: assert property (
    $rose(wdt_rst_out_ff) |-> $fell(wdt_active_ff)) else $error("expiry did not stop counting");
  stay_on_a: assert property (
    $fell(wdt_active_ff) |-> wdt_rst_out_ff) else $error("watchdog stopped without expiry");
  key_on_a: assert property (
    $past(k1) && k2 && !wdt_rst_out_ff |-> ##2 wdt_active_ff) else $error("key pair ignored");
  key_only_a: assert property (
    $rose(wdt_active_ff) |-> $past(k2, 2)) else $error("enabled without key");
  rd_zero_a: assert property (
    $past(reg_rd) && $past(reg_addr) != 8'hA7 |-> reg_rdata_ff == 8'h00) else $error("read leaks state");
  rd_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata_ff == 8'h00) else $error("read data not cleared");
endmodule // hwwdt_top_chk
bind hwwdt_top hwwdt_top_chk u_chk (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .int_hold(int_hold),
  .wdt_rst_out_ff(wdt_rst_out_ff), .wdt_active_ff(wdt_active_ff));
`default_nettype wire

// file: tb/hardware_watchdog_timer_bench.sv
/* Self-checking bench for hwwdt_top: key pairs, timeouts, pulse, reads.
 Assumes the bench drives every port; no far-side model. */
`default_nettype none
module hardware_watchdog_timer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n, reg_wr, reg_rd, int_hold, wdt_rst_out_ff, wdt_active_ff;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_ff, v;
  logic [31:0] seed = 32'hb8f7;
  int fail_count = 0;
  int checked = 0;
  int n;
  `define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
  hwwdt_top DUT (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .int_hold(int_hold),
    .wdt_rst_out_ff(wdt_rst_out_ff), .wdt_active_ff(wdt_active_ff));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  task automatic idle();
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic key();
    wr(8'hA6, 8'h1E);
    wr(8'hA6, 8'hE1);
    idle();
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata_ff;
  endtask
  // model: pulse edge counted from the edge taking the second key;
  // timeout 2^(14+sel)-1 counts, plus one cycle to start and one to fire
  task automatic run(input int pre, input int e);
    n = pre;
    while (wdt_rst_out_ff !== 1'b1 && n < 40000) begin
      @(posedge clk);
      #1 n++;
    end
    `CHK(n, e)
    n = 0;
    while (wdt_rst_out_ff === 1'b1) begin
      @(posedge clk);
      #1 n++;
    end
    `CHK(n, 96)
    `CHK(wdt_active_ff, 1'b0)
  endtask
  task automatic test_done();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #500us;
    fail_count++;
    test_done();
  end
  initial begin
    {rst_n, reg_wr, reg_rd, int_hold, reg_addr, reg_wdata} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'hA7);
    `CHK(v[2:0], 3'h0)
    rd(8'hA6);
    `CHK(v, 8'h00)
    wr(8'hA6, 8'h1E);
    wr(8'hA6, 8'h55);
    wr(8'hA6, 8'hE1);
    wr(8'hA6, 8'hE1);
    idle();
    repeat (4) @(posedge clk);
    #1 `CHK(wdt_active_ff, 1'b0)
    key();
    run(0, (1 << 14) - 1 + 2);
    key();
    for (int i = 0; i < 2000; i++) begin
      v = 8'(rnd());
      wr({1'b0, v[6:0]}, 8'(rnd()));
    end
    idle();
    #1 `CHK(wdt_active_ff, 1'b1)
    key();
    run(0, (1 << 14) - 1 + 2);
    wr(8'hA7, 8'hF9);
    idle();
    rd(8'hA7);
    `CHK(v, 8'hF9)
    key();
    repeat (50) @(posedge clk);
    int_hold <= 1'b1;
    repeat (100) @(posedge clk);
    int_hold <= 1'b0;
    run(150, (1 << 15) - 1 + 2 + 100);
    key();
    repeat (10) @(posedge clk);
    #1 `CHK(wdt_active_ff, 1'b1)
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1 `CHK(wdt_active_ff, 1'b0)
    `CHK(wdt_rst_out_ff, 1'b0)
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'hA7);
    `CHK(v[2:0], 3'h0)
    `CHK(wdt_active_ff, 1'b0)
    test_done();
  end
endmodule // hardware_watchdog_timer_bench
`default_nettype wire
